// File: include/qcms_pkg.sv
// Constants, types and opcodes of the quad command mode switch.
package qcms_pkg;

  // ==========================================================================
  // Clock and timing.
  localparam int CLK_MHZ          = 50;
  localparam int POWER_UP_WAIT_US = 700;
  localparam int POWER_UP_CYCLES  = POWER_UP_WAIT_US * CLK_MHZ;

  // ==========================================================================
  // Command opcodes.
  localparam logic [7:0] CMD_ENTER_QUAD = 8'h38;
  localparam logic [7:0] CMD_EXIT_QUAD  = 8'hFF;
  localparam logic [7:0] CMD_SFDP_READ  = 8'h5A;
  localparam logic [7:0] CMD_READ_PARAM = 8'hC0;

  // ==========================================================================
  // Frame layout counts.
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS   = 5'h18;
  localparam logic [4:0] SFDP_DUMMY  = 5'h08;
  localparam logic [4:0] STEP_SINGLE = 5'h01;
  localparam logic [4:0] STEP_QUAD   = 5'h04;
  localparam logic [2:0] OUT_LAST_SINGLE = 3'h7;
  localparam logic [2:0] OUT_LAST_QUAD   = 3'h1;
  localparam logic [3:0] OE_SINGLE   = 4'h2;
  localparam logic [3:0] OE_QUAD     = 4'hF;

  // ==========================================================================
  // Register map, field positions and reset values.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PARAM  = 8'h04;
  localparam logic [7:0] REG_MODE   = 8'h08;
  localparam int STATUS_WEL_BIT = 0;
  localparam int STATUS_QE_BIT  = 1;
  localparam int STATUS_SUS_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PARAM_RESET  = 8'h00;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;

  // ==========================================================================
  // Discoverable parameter table.
  localparam logic [23:0] SFDP_TABLE_LEN = 24'h000008;
  localparam logic [7:0]  SFDP_SIG0 = 8'h53;
  localparam logic [7:0]  SFDP_SIG1 = 8'h46;
  localparam logic [7:0]  SFDP_SIG2 = 8'h44;
  localparam logic [7:0]  SFDP_SIG3 = 8'h50;
  // Revision codes are arbitrary values.
  localparam logic [7:0]  SFDP_MINOR = 8'h01;
  localparam logic [7:0]  SFDP_MAJOR = 8'h01;
  localparam logic [7:0]  SFDP_NPH   = 8'h00;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR   = 3'h2,
    ST_DUMMY  = 3'h3,
    ST_DATA   = 3'h4,
    ST_PARAM  = 3'h5,
    ST_IGNORE = 3'h6
  } qcms_state_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] io;
  } qcms_pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } qcms_bus_t;

endpackage

// File: verilog/qcms_top.sv
// Mode switch and parameter read logic of the serial flash command port.
//
// Function
// - 38H in single-line mode with quad_enable set enters four-line mode.
// - 38H with quad_enable clear is ignored and single-line mode stays.
// - Entering four-line mode keeps write enable, suspend and wrap length.
// - Opcode FFH in four-line mode returns to single-line mode.
// - Leaving four-line mode keeps write enable, suspend and wrap length.
// - Opcode 5AH is served in both modes and returns the parameter table.
// - After reset the status reads 00H and unwritten bytes read FFH.
// - Opcode C0H loads the next byte into the wrap length register; the dummy clock count stays fixed at 8.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps

module qcms_top #(
  parameter int POWER_UP_CYCLES = qcms_pkg::POWER_UP_CYCLES
) (
  // Clock and reset.
  input  logic               mclk,
  input  logic               rst,
  // Serial pins.
  input  qcms_pkg::qcms_pins_t pins,
  output logic [3:0]         io_out,
  output logic [3:0]         io_oe,
  // Register port.
  input  qcms_pkg::qcms_bus_t bus,
  output logic [7:0]         rdata,
  // Mode flag.
  output logic               four_line_command_mode
);

  // The power-up counter is 16 bits wide.
  if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES > 65535) begin : g_bad_wait
    $error("POWER_UP_CYCLES out of range");
  end

  // ==========================================================================
  // Helpers.
  function automatic logic [7:0] qcms_shift(input logic [7:0] sr,
                                            input logic [3:0] io,
                                            input logic       quad);
    return quad ? {sr[3:0], io} : {sr[6:0], io[0]};
  endfunction

  function automatic logic [4:0] qcms_step(input logic quad);
    return quad ? qcms_pkg::STEP_QUAD : qcms_pkg::STEP_SINGLE;
  endfunction

  function automatic logic [7:0] qcms_sfdp(input logic [23:0] a);
    logic [7:0] b;
    b = qcms_pkg::ERASED_BYTE;
    case (a)
      24'h000000: b = qcms_pkg::SFDP_SIG0;
      24'h000001: b = qcms_pkg::SFDP_SIG1;
      24'h000002: b = qcms_pkg::SFDP_SIG2;
      24'h000003: b = qcms_pkg::SFDP_SIG3;
      24'h000004: b = qcms_pkg::SFDP_MINOR;
      24'h000005: b = qcms_pkg::SFDP_MAJOR;
      24'h000006: b = qcms_pkg::SFDP_NPH;
      default:    b = qcms_pkg::ERASED_BYTE;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // Pin synchronisers and clock edge detection.
  logic       sclk_s1;
  logic       sclk_s2;
  logic       sclk_s3;
  logic       cs_s1;
  logic       cs_s2;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic       rise;
  logic       fall;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      io_s1   <= 4'h0;
      io_s2   <= 4'h0;
    end else begin
      sclk_s1 <= pins.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1   <= pins.cs_n;
      cs_s2   <= cs_s1;
      io_s1   <= pins.io;
      io_s2   <= io_s1;
    end
  end

  assign rise = sclk_s2 & ~sclk_s3;
  assign fall = ~sclk_s2 & sclk_s3;

  // ==========================================================================
  // Power-up wait counter.
  logic [15:0] pwr_cnt;
  logic        pwr_done;
  logic [15:0] next_pwr_cnt;
  logic        next_pwr_done;

  always_comb begin
    next_pwr_cnt  = pwr_cnt;
    next_pwr_done = pwr_done;
    if (!pwr_done) begin
      next_pwr_cnt = pwr_cnt + 16'h0001;
      if (pwr_cnt == 16'(POWER_UP_CYCLES - 1)) begin
        next_pwr_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_cnt  <= 16'h0000;
      pwr_done <= 1'b0;
    end else begin
      pwr_cnt  <= next_pwr_cnt;
      pwr_done <= next_pwr_done;
    end
  end

  // ==========================================================================
  // Command frame engine.
  qcms_pkg::qcms_state_t state;
  qcms_pkg::qcms_state_t next_state;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [7:0]  sr;
  logic [7:0]  next_sr;
  logic [23:0] sfdp_addr;
  logic [23:0] next_sfdp_addr;
  logic [7:0]  out_sr;
  logic [7:0]  next_out_sr;
  logic [2:0]  out_cnt;
  logic [2:0]  next_out_cnt;
  logic [3:0]  next_io_out;
  logic [3:0]  next_io_oe;
  logic        next_quad;
  logic [7:0]  new_sr;
  logic [4:0]  new_cnt;
  logic [7:0]  out_byte;
  logic        opc_done;
  logic        param_load;
  logic [7:0]  status;
  logic [7:0]  param;

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_sr        = sr;
    next_sfdp_addr = sfdp_addr;
    next_out_sr    = out_sr;
    next_out_cnt   = out_cnt;
    next_io_out    = io_out;
    next_io_oe     = io_oe;
    next_quad      = four_line_command_mode;
    opc_done       = 1'b0;
    param_load     = 1'b0;
    out_byte       = qcms_sfdp(sfdp_addr);
    new_sr         = qcms_shift(sr, io_s2, four_line_command_mode);
    new_cnt        = bit_cnt + qcms_step(four_line_command_mode);
    if (cs_s2) begin
      next_state   = qcms_pkg::ST_IDLE;
      next_bit_cnt = 5'h00;
      next_io_oe   = 4'h0;
      next_io_out  = 4'h0;
    end else begin
      case (state)
        qcms_pkg::ST_IDLE: begin
          next_bit_cnt = 5'h00;
          // Frames begun before the power-up wait are dropped whole.
          next_state = pwr_done ? qcms_pkg::ST_OPCODE
                                : qcms_pkg::ST_IGNORE;
        end
        qcms_pkg::ST_OPCODE: begin
          if (rise) begin
            next_sr      = new_sr;
            next_bit_cnt = new_cnt;
            if (new_cnt == qcms_pkg::OPCODE_BITS) begin
              opc_done     = 1'b1;
              next_bit_cnt = 5'h00;
              next_state   = qcms_pkg::ST_IGNORE;
              case (new_sr)
                qcms_pkg::CMD_ENTER_QUAD: begin
                  if (status[qcms_pkg::STATUS_QE_BIT]) begin
                    next_quad = 1'b1;
                  end
                end
                qcms_pkg::CMD_EXIT_QUAD: begin
                  next_quad = 1'b0;
                end
                qcms_pkg::CMD_SFDP_READ: begin
                  next_state = qcms_pkg::ST_ADDR;
                end
                qcms_pkg::CMD_READ_PARAM: begin
                  next_state = qcms_pkg::ST_PARAM;
                end
                default: begin
                  next_state = qcms_pkg::ST_IGNORE;
                end
              endcase
            end
          end
        end
        qcms_pkg::ST_ADDR: begin
          if (rise) begin
            next_sfdp_addr = four_line_command_mode ?
                             {sfdp_addr[19:0], io_s2} :
                             {sfdp_addr[22:0], io_s2[0]};
            next_bit_cnt = new_cnt;
            if (new_cnt == qcms_pkg::ADDR_BITS) begin
              next_bit_cnt = 5'h00;
              next_state   = qcms_pkg::ST_DUMMY;
            end
          end
        end
        qcms_pkg::ST_DUMMY: begin
          if (rise) begin
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt + 5'h01 == qcms_pkg::SFDP_DUMMY) begin
              next_state   = qcms_pkg::ST_DATA;
              next_out_cnt = 3'h0;
              next_io_oe   = four_line_command_mode ? qcms_pkg::OE_QUAD
                                                    : qcms_pkg::OE_SINGLE;
            end
          end
        end
        qcms_pkg::ST_DATA: begin
          if (fall) begin
            if (out_cnt == 3'h0) begin
              // Bytes past the table read as erased memory.
              next_sfdp_addr = sfdp_addr + 24'h000001;
              if (four_line_command_mode) begin
                next_io_out  = out_byte[7:4];
                next_out_sr  = {out_byte[3:0], 4'h0};
                next_out_cnt = qcms_pkg::OUT_LAST_QUAD;
              end else begin
                next_io_out  = {2'b00, out_byte[7], 1'b0};
                next_out_sr  = {out_byte[6:0], 1'b0};
                next_out_cnt = qcms_pkg::OUT_LAST_SINGLE;
              end
            end else begin
              next_out_cnt = out_cnt - 3'h1;
              if (four_line_command_mode) begin
                next_io_out = out_sr[7:4];
                next_out_sr = {out_sr[3:0], 4'h0};
              end else begin
                next_io_out = {2'b00, out_sr[7], 1'b0};
                next_out_sr = {out_sr[6:0], 1'b0};
              end
            end
          end
        end
        qcms_pkg::ST_PARAM: begin
          if (rise) begin
            next_sr      = new_sr;
            next_bit_cnt = new_cnt;
            if (new_cnt == qcms_pkg::OPCODE_BITS) begin
              param_load = 1'b1;
              next_state = qcms_pkg::ST_IGNORE;
            end
          end
        end
        qcms_pkg::ST_IGNORE: begin
          next_state = qcms_pkg::ST_IGNORE;
        end
        default: begin
          next_state = qcms_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state                  <= qcms_pkg::ST_IDLE;
      bit_cnt                <= 5'h00;
      sr                     <= 8'h00;
      sfdp_addr              <= 24'h000000;
      out_sr                 <= 8'h00;
      out_cnt                <= 3'h0;
      io_out                 <= 4'h0;
      io_oe                  <= 4'h0;
      four_line_command_mode <= 1'b0;
    end else begin
      state                  <= next_state;
      bit_cnt                <= next_bit_cnt;
      sr                     <= next_sr;
      sfdp_addr              <= next_sfdp_addr;
      out_sr                 <= next_out_sr;
      out_cnt                <= next_out_cnt;
      io_out                 <= next_io_out;
      io_oe                  <= next_io_oe;
      four_line_command_mode <= next_quad;
    end
  end

  // ==========================================================================
  // Register file.
  logic [7:0] next_status;
  logic [7:0] next_param;
  logic [7:0] next_rdata;

  // Mode switches never touch status or param, so both survive them.
  always_comb begin
    next_status = status;
    next_param  = param;
    next_rdata  = 8'h00;
    if (bus.wr) begin
      case (bus.addr)
        qcms_pkg::REG_STATUS: next_status = bus.wdata;
        qcms_pkg::REG_PARAM:  next_param  = bus.wdata;
        default:              next_status = status;
      endcase
    end
    if (param_load) begin
      next_param = new_sr;
    end
    if (bus.rd) begin
      case (bus.addr)
        qcms_pkg::REG_STATUS: next_rdata = status;
        qcms_pkg::REG_PARAM:  next_rdata = param;
        qcms_pkg::REG_MODE:   next_rdata = {6'h00, pwr_done,
                                            four_line_command_mode};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status <= qcms_pkg::STATUS_RESET;
      param  <= qcms_pkg::PARAM_RESET;
      rdata  <= 8'h00;
    end else begin
      status <= next_status;
      param  <= next_param;
      rdata  <= next_rdata;
    end
  end

  // ==========================================================================
  // Assertions.
  logic first_cycle;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_enter;
    opc_done && new_sr == qcms_pkg::CMD_ENTER_QUAD && !four_line_command_mode
      && status[qcms_pkg::STATUS_QE_BIT] |=> four_line_command_mode;
  endproperty
  a_enter: assert property (p_enter)
    else $error("quad entry missed");

  property p_no_qe;
    opc_done && new_sr == qcms_pkg::CMD_ENTER_QUAD && !four_line_command_mode
      && !status[qcms_pkg::STATUS_QE_BIT] |=> !four_line_command_mode [*2];
  endproperty
  a_no_qe: assert property (p_no_qe)
    else $error("entry without qe");

  property p_keep_in;
    opc_done && new_sr == qcms_pkg::CMD_ENTER_QUAD && !bus.wr
      |=> $stable(status) && $stable(param);
  endproperty
  a_keep_in: assert property (p_keep_in)
    else $error("state lost on entry");

  property p_exit;
    opc_done && new_sr == qcms_pkg::CMD_EXIT_QUAD && four_line_command_mode
      |=> !four_line_command_mode;
  endproperty
  a_exit: assert property (p_exit)
    else $error("quad exit missed");

  property p_keep_out;
    opc_done && new_sr == qcms_pkg::CMD_EXIT_QUAD && !bus.wr
      |=> $stable(status) && $stable(param);
  endproperty
  a_keep_out: assert property (p_keep_out)
    else $error("state lost on exit");

  property p_sfdp;
    opc_done && new_sr == qcms_pkg::CMD_SFDP_READ
      |=> state == qcms_pkg::ST_ADDR;
  endproperty
  a_sfdp: assert property (p_sfdp)
    else $error("sfdp read refused");

  property p_delivered;
    first_cycle |-> status == qcms_pkg::STATUS_RESET
      && !four_line_command_mode && rdata == 8'h00;
  endproperty
  a_delivered: assert property (p_delivered)
    else $error("bad reset state");

  property p_erased;
    state == qcms_pkg::ST_DATA && fall && !cs_s2 && out_cnt == 3'h0
      && sfdp_addr >= qcms_pkg::SFDP_TABLE_LEN
      |=> (four_line_command_mode ? io_out == 4'hF : io_out[1]);
  endproperty
  a_erased: assert property (p_erased)
    else $error("erased byte not FF");

  property p_param;
    param_load |=> param == sr && state == qcms_pkg::ST_IGNORE;
  endproperty
  a_param: assert property (p_param)
    else $error("param not loaded");

  property p_quad_nibble;
    four_line_command_mode && state == qcms_pkg::ST_OPCODE && rise
      && bit_cnt == 5'h00 && !cs_s2 |=> bit_cnt == qcms_pkg::STEP_QUAD;
  endproperty
  a_quad_nibble: assert property (p_quad_nibble)
    else $error("not 4 bits");

  property p_wait;
    !pwr_done |-> state == qcms_pkg::ST_IDLE || state == qcms_pkg::ST_IGNORE;
  endproperty
  a_wait: assert property (p_wait)
    else $error("command before wait");

  c_enter: cover property (!four_line_command_mode ##1 four_line_command_mode);
  c_exit:  cover property (four_line_command_mode ##1 !four_line_command_mode);
  c_data:  cover property (state == qcms_pkg::ST_DATA && fall);
  c_param: cover property (param_load);

endmodule

// File: sim/qcms_host.sv
// Host flash controller model that drives the serial link of the block.
`timescale 1ns/100ps

module qcms_host #(
  parameter int HALF = 4
) (
  // Clock.
  input  wire logic       mclk,
  // Serial pins toward the device.
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_drv,
  output logic [3:0]      io_en,
  // Resolved data lines.
  input  wire logic [3:0] io
);

  logic quad;

  initial begin
    sclk   = 1'b0;
    cs_n   = 1'b1;
    io_drv = 4'h0;
    io_en  = 4'h0;
    quad   = 1'b0;
  end

  // ==========================================================================
  // Serial clock beats.

  // One clock: data change while low, sample just before the next fall.
  task automatic beat(input logic [3:0] d, input logic [3:0] en,
                      output logic [3:0] q);
    sclk   <= 1'b0;
    io_drv <= d;
    io_en  <= en;
    repeat (HALF) @(posedge mclk);
    sclk <= 1'b1;
    repeat (HALF - 1) @(posedge mclk);
    q = io;
    @(posedge mclk);
  endtask

  task automatic lanes(input logic q4);
    quad = q4;
  endtask

  // Four-line mode moves a nibble per clock, opcode included.
  task automatic send_byte(input logic [7:0] b);
    logic [3:0] q;
    if (quad) begin
      beat(b[7:4], 4'hF, q);
      beat(b[3:0], 4'hF, q);
    end else begin
      for (int i = 7; i >= 0; i--) beat({3'h0, b[i]}, 4'h1, q);
    end
  endtask

  task automatic get_byte(output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    if (quad) begin
      beat(4'h0, 4'h0, q);
      b[7:4] = q;
      beat(4'h0, 4'h0, q);
      b[3:0] = q;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        beat(4'h0, 4'h0, q);
        b[i] = q[1];
      end
    end
  endtask

  // ==========================================================================
  // Frames.

  task automatic begin_frame();
    cs_n <= 1'b0;
    repeat (HALF) @(posedge mclk);
  endtask

  // The clock parks low and the lines are released between frames.
  task automatic end_frame();
    sclk  <= 1'b0;
    io_en <= 4'h0;
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (2 * HALF) @(posedge mclk);
  endtask

  task automatic cmd(input logic [7:0] op);
    begin_frame();
    send_byte(op);
    end_frame();
  endtask

  task automatic cmd_data(input logic [7:0] op, input logic [7:0] d);
    begin_frame();
    send_byte(op);
    send_byte(d);
    end_frame();
  endtask

  task automatic sfdp(input logic [23:0] a, input int n,
                      output logic [7:0] got [$]);
    logic [7:0] b;
    logic [3:0] q;
    got = {};
    begin_frame();
    send_byte(qcms_pkg::CMD_SFDP_READ);
    for (int i = 2; i >= 0; i--) send_byte(a[8*i +: 8]);
    repeat (8) beat(4'h0, 4'h0, q);
    for (int i = 0; i < n; i++) begin
      get_byte(b);
      got.push_back(b);
    end
    end_frame();
  endtask

endmodule

// File: sim/testbench.sv
// Self-checking testbench of the quad command mode switch.
`timescale 1ns/100ps

module testbench;

  localparam int PWR = 20;
  localparam logic [7:0] TBL [8] = '{qcms_pkg::SFDP_SIG0,
    qcms_pkg::SFDP_SIG1, qcms_pkg::SFDP_SIG2, qcms_pkg::SFDP_SIG3,
    qcms_pkg::SFDP_MINOR, qcms_pkg::SFDP_MAJOR, qcms_pkg::SFDP_NPH,
    qcms_pkg::ERASED_BYTE};

  logic                 mclk = 1'b0;
  logic                 rst  = 1'b1;
  qcms_pkg::qcms_pins_t pins;
  qcms_pkg::qcms_bus_t  bus  = '0;
  logic                 sclk;
  logic                 cs_n;
  logic [3:0]           io_out;
  logic [3:0]           io_oe;
  logic [3:0]           io_drv;
  logic [3:0]           io_en;
  logic [3:0]           io_wire;
  logic [3:0]           float_io = 4'h5;
  logic [7:0]           rdata;
  logic                 four_line_command_mode;
  int                   errors = 0;
  int                   checks = 0;

  always #10 mclk = ~mclk;

  // Lines nobody drives keep changing so stale values never match.
  always @(posedge mclk) float_io <= ~float_io;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_wire[i] = io_oe[i] ? io_out[i]
                 : (io_en[i] ? io_drv[i] : float_io[i]);
    end
  end

  assign pins = {sclk, cs_n, io_wire};

  qcms_top #(.POWER_UP_CYCLES(PWR)) DUT (
    .mclk                   (mclk),
    .rst                    (rst),
    .pins                   (pins),
    .io_out                 (io_out),
    .io_oe                  (io_oe),
    .bus                    (bus),
    .rdata                  (rdata),
    .four_line_command_mode (four_line_command_mode)
  );

  qcms_host #(.HALF(4)) u_host (
    .mclk   (mclk),
    .sclk   (sclk),
    .cs_n   (cs_n),
    .io_drv (io_drv),
    .io_en  (io_en),
    .io     (io_wire)
  );

  // ==========================================================================
  // Checking and register access.

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge mclk);
  endtask

  task automatic sfdp_chk(input logic [23:0] a, input int n);
    logic [7:0] got [$];
    int         idx;
    u_host.sfdp(a, n, got);
    for (int i = 0; i < n; i++) begin
      idx = int'(a) + i;
      check(got[i], (idx < 8) ? TBL[idx] : qcms_pkg::ERASED_BYTE);
    end
  endtask

  // ==========================================================================
  // Test sequence.

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reg_chk(qcms_pkg::REG_STATUS, 8'h00);
    reg_chk(qcms_pkg::REG_PARAM, 8'h00);
    reg_chk(qcms_pkg::REG_MODE, 8'h00);
    // A frame begun inside the power-up wait is dropped whole.
    reg_wr(qcms_pkg::REG_STATUS, 8'h02);
    u_host.cmd(qcms_pkg::CMD_ENTER_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h02);
    reg_wr(qcms_pkg::REG_STATUS, 8'h00);
    reg_wr(8'h0C, 8'hFF);
    reg_chk(8'h0C, 8'h00);
    repeat (PWR + 2) @(posedge mclk);
    reg_chk(qcms_pkg::REG_MODE, 8'h02);
    sfdp_chk(24'h000000, 10);
    u_host.cmd(qcms_pkg::CMD_ENTER_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h02);
    reg_wr(qcms_pkg::REG_STATUS, 8'h07);
    // Bits after an unknown opcode must not act as a command.
    u_host.cmd_data(8'h06, qcms_pkg::CMD_ENTER_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h02);
    u_host.cmd_data(qcms_pkg::CMD_READ_PARAM, 8'hA5);
    reg_chk(qcms_pkg::REG_PARAM, 8'hA5);
    u_host.cmd(qcms_pkg::CMD_ENTER_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h03);
    check({7'h00, four_line_command_mode}, 8'h01);
    reg_chk(qcms_pkg::REG_STATUS, 8'h07);
    reg_chk(qcms_pkg::REG_PARAM, 8'hA5);
    u_host.lanes(1'b1);
    sfdp_chk(24'h000006, 4);
    u_host.cmd_data(qcms_pkg::CMD_READ_PARAM, 8'h3C);
    reg_chk(qcms_pkg::REG_PARAM, 8'h3C);
    u_host.cmd(qcms_pkg::CMD_ENTER_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h03);
    u_host.cmd(qcms_pkg::CMD_EXIT_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h02);
    check({7'h00, four_line_command_mode}, 8'h00);
    reg_chk(qcms_pkg::REG_STATUS, 8'h07);
    reg_chk(qcms_pkg::REG_PARAM, 8'h3C);
    u_host.lanes(1'b0);
    u_host.cmd(qcms_pkg::CMD_EXIT_QUAD);
    reg_chk(qcms_pkg::REG_MODE, 8'h02);
    sfdp_chk(24'h000002, 2);
    summarize();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    summarize();
  end

endmodule
